// File: common/msf_pkg.sv
`default_nettype none
package msf_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int FLAG_N = 6;
  localparam int CURR_W = 11;
  localparam int HALF_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'h00;
  localparam logic [7:0] OFS_SPEED = 8'h01;
  localparam logic [7:0] OFS_PERIOD = 8'h02;
  localparam logic [7:0] OFS_VEL_CONST = 8'h03;
  localparam logic [7:0] OFS_PEAK_CURR = 8'h04;
  localparam logic [7:0] OFS_POS_SUPPLY = 8'h05;
  // Fault flag bit positions
  localparam int BIT_HW_CURRENT_LIMIT = 0;
  localparam int BIT_SPEED_ABNORMAL = 1;
  localparam int BIT_VEL_CONST_ABNORMAL = 2;
  localparam int BIT_NO_MOTOR = 3;
  localparam int BIT_OPEN_LOOP_STUCK = 4;
  localparam int BIT_CLOSED_LOOP_STUCK = 5;
  localparam int BIT_FAULT_RSVD = 6;
  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [5:0] RST_FLAGS = 6'h00;
  // Scaling of readback words, for software
  localparam int SPEED_DIV = 10;
  localparam int PERIOD_MUL_US = 10;
  localparam int VEL_CONST_DIV_A = 2;
  localparam int VEL_CONST_DIV_B = 1090;
  localparam int CURR_OFFSET = 1023;
  localparam int CURR_DIV = 512;
  localparam int CURR_MUL = 3;
endpackage : msf_pkg
`default_nettype wire

// File: src/msf_status_regs.sv
// Overview of operation
// - Six sticky lock-fault flags, bits five to zero
// - Speed word at 0x01, hertz is value/10
// - Period word at 0x02, microseconds is value*10
// - Velocity constant word at 0x03, value/2/1090
// - Peak current eleven bits at 0x04
// - Peak current bits 15:11 read zero
// - Feedback words reset zero, ignore writes
`default_nettype none
module msf_status_regs
  import msf_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register access from the two-wire interface engine
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rd_valid,
  // Fault events from the motor control core
  input wire logic [FLAG_N-1:0] fault_event,
  // Live measurements from the motor control core
  input wire logic [DATA_W-1:0] speed_value,
  input wire logic [DATA_W-1:0] period_value,
  input wire logic [DATA_W-1:0] velocity_const_value,
  input wire logic [CURR_W-1:0] peak_current_value,
  input wire logic [HALF_W-1:0] initial_position_estimate,
  input wire logic [HALF_W-1:0] supply_level_value,
  // Flag state for the core
  output logic [FLAG_N-1:0] fault_flags
);

  logic [DATA_W-1:0] motor_speed_readback;
  logic [DATA_W-1:0] motor_period_readback;
  logic [DATA_W-1:0] velocity_constant_readback;
  logic [CURR_W-1:0] peak_current_readback;
  logic [DATA_W-1:0] position_and_supply_readback;

  wire sel_fault = (reg_addr == OFS_FAULT_FLAGS);
  wire sel_speed = (reg_addr == OFS_SPEED);
  wire sel_period = (reg_addr == OFS_PERIOD);
  wire sel_vel = (reg_addr == OFS_VEL_CONST);
  wire sel_curr = (reg_addr == OFS_PEAK_CURR);
  wire sel_pos = (reg_addr == OFS_POS_SUPPLY);

  // Write-one-to-clear mask; reserved bit six has no storage
  wire [FLAG_N-1:0] clear_mask = (reg_wr_en && sel_fault) ? reg_wdata[FLAG_N-1:0] : RST_FLAGS;
  // Set wins over a clear in the same cycle
  wire [FLAG_N-1:0] next_fault_flags = (fault_flags & ~clear_mask) | fault_event;

  wire [DATA_W-1:0] fault_word = {{(DATA_W-FLAG_N){1'b0}}, fault_flags};
  wire [DATA_W-1:0] curr_word = {{(DATA_W-CURR_W){1'b0}}, peak_current_readback};
  wire [DATA_W-1:0] next_reg_rdata =
    sel_fault  ? fault_word :
    sel_speed  ? motor_speed_readback :
    sel_period ? motor_period_readback :
    sel_vel    ? velocity_constant_readback :
    sel_curr   ? curr_word :
    sel_pos    ? position_and_supply_readback : RST_WORD;

  always_ff @(posedge mclk) begin
    if (reset) begin
      fault_flags <= RST_FLAGS;
    end else begin
      fault_flags <= next_fault_flags;
    end
  end

  // Feedback words track the core; bus writes never reach them
  always_ff @(posedge mclk) begin
    if (reset) begin
      motor_speed_readback <= RST_WORD;
      motor_period_readback <= RST_WORD;
      velocity_constant_readback <= RST_WORD;
      peak_current_readback <= RST_WORD[CURR_W-1:0];
      position_and_supply_readback <= RST_WORD;
    end else begin
      motor_speed_readback <= speed_value;
      motor_period_readback <= period_value;
      velocity_constant_readback <= velocity_const_value;
      peak_current_readback <= peak_current_value;
      position_and_supply_readback <= {initial_position_estimate, supply_level_value};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= RST_WORD;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= next_reg_rdata;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_FLAG_SET: assert property ((|fault_event) |=> ((fault_flags & $past(fault_event)) == $past(fault_event)))
    else $error("Fault event did not set its flag");
  AST_FLAG_CLEAR: assert property ((reg_wr_en && sel_fault && fault_event == 6'h00)
      |=> ((fault_flags & $past(reg_wdata[FLAG_N-1:0])) == 6'h00))
    else $error("Write one did not clear the flag");
  AST_FLAG_STICKY: assert property (!(reg_wr_en && sel_fault)
      |=> ((fault_flags & $past(fault_flags)) == $past(fault_flags)))
    else $error("Fault flag dropped without a clear");
  AST_FAULT_RSVD: assert property ((reg_rd_en && sel_fault) |=> (reg_rd_valid && reg_rdata[15:6] == 10'h000))
    else $error("Fault upper bits read nonzero");
  AST_SPEED_RD: assert property ((reg_rd_en && sel_speed && !$past(reset)) |=> (reg_rdata == $past(speed_value, 2)))
    else $error("Speed readback wrong");
  AST_PERIOD_RD: assert property ((reg_rd_en && sel_period && !$past(reset)) |=> (reg_rdata == $past(period_value, 2)))
    else $error("Period readback wrong");
  AST_VEL_RD: assert property ((reg_rd_en && sel_vel && !$past(reset))
      |=> (reg_rdata == $past(velocity_const_value, 2)))
    else $error("Velocity constant readback wrong");
  AST_CURR_RD: assert property ((reg_rd_en && sel_curr && !$past(reset))
      |=> (reg_rdata[10:0] == $past(peak_current_value, 2) && reg_rdata[15:11] == 5'h00))
    else $error("Peak current readback wrong");
  AST_RO_WRITE: assert property ((reg_wr_en && sel_speed) |=> (motor_speed_readback == $past(speed_value)))
    else $error("Write reached a read-only word");
  AST_PERIOD_RO: assert property ((reg_wr_en && sel_period)
      |=> (motor_period_readback == $past(period_value)))
    else $error("Write reached the period word");
  AST_VEL_RO: assert property ((reg_wr_en && sel_vel)
      |=> (velocity_constant_readback == $past(velocity_const_value)))
    else $error("Write reached the velocity constant word");
  AST_CURR_RO: assert property ((reg_wr_en && sel_curr)
      |=> (peak_current_readback == $past(peak_current_value)))
    else $error("Write reached the peak current word");
  AST_POS_RO: assert property ((reg_wr_en && sel_pos)
      |=> (position_and_supply_readback == {$past(initial_position_estimate), $past(supply_level_value)}))
    else $error("Write reached the position and supply word");

  // Position and supply word packs two bytes
  AST_POS_RD: assert property ((reg_rd_en && sel_pos && !$past(reset))
      |=> (reg_rdata == {$past(initial_position_estimate, 2), $past(supply_level_value, 2)}))
    else $error("Position and supply readback wrong");

  // Reads outside the map return zero
  AST_UNMAPPED_RD: assert property ((reg_rd_en && reg_addr > OFS_POS_SUPPLY)
      |=> (reg_rdata == RST_WORD))
    else $error("Unmapped read returned nonzero");

  // Read handshake: one valid pulse per strobe
  AST_RD_VALID: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("Read strobe got no valid pulse");
  AST_NO_RD_NO_VALID: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("Valid pulse without a read strobe");
  AST_RDATA_HOLD: assert property (!reg_rd_en |=> $stable(reg_rdata))
    else $error("Read data moved without a read");

  // A set in the same cycle as its clear must win
  AST_SET_WINS: assert property ((|(fault_event & clear_mask))
      |=> ((fault_flags & $past(fault_event)) == $past(fault_event)))
    else $error("Clear beat a simultaneous fault event");
  // No flag rises without its event
  AST_NO_SPURIOUS: assert property ((fault_event == 6'h00)
      |=> ((fault_flags & ~$past(fault_flags)) == 6'h00))
    else $error("Fault flag rose without an event");

  // Reset leaves flags and read handshake idle
  AST_RESET_CLEAN: assert property (@(posedge mclk) disable iff (1'b0)
      reset |=> (fault_flags == RST_FLAGS && !reg_rd_valid && reg_rdata == RST_WORD))
    else $error("Reset did not clear flags and read port");
  AST_RESET_WORDS: assert property (@(posedge mclk) disable iff (1'b0)
      reset |=> (motor_speed_readback == RST_WORD && motor_period_readback == RST_WORD))
    else $error("Reset did not clear feedback words");

  COV_FLAG_SET_CLEAR: cover property ((|fault_event) ##1 (reg_wr_en && sel_fault && (|reg_wdata[5:0])));
  COV_SET_AND_CLEAR: cover property (reg_wr_en && sel_fault && (|(fault_event & reg_wdata[5:0])));
  COV_CURR_READ: cover property (reg_rd_en && sel_curr ##1 reg_rd_valid);
  COV_POS_READ: cover property (reg_rd_en && sel_pos ##1 reg_rd_valid);

endmodule : msf_status_regs
`default_nettype wire

// File: sim/msf_host_model.sv
`default_nettype none
module msf_host_model
  import msf_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Register port toward the block
  output logic wr_en,
  output logic rd_en,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic rd_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
  end
  // One strobe cycle, answer taken one cycle later; no answer reads as unknown
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
    output logic [DATA_W-1:0] q);
    @(posedge mclk);
    wr_en <= w;
    rd_en <= !w;
    addr <= a;
    wdata <= d & 16'hffbf;
    @(posedge mclk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    #1 q = (rd_valid === 1'b1) ? rdata : 16'hxxxx;
  endtask : access
endmodule : msf_host_model
`default_nettype wire

// File: sim/msf_status_regs_bench.sv
`default_nettype none
module msf_status_regs_bench import msf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, reset = 1, wr, rd, rv;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, q, spd = 0, per = 0, kt = 0;
  logic [CURR_W-1:0] cur = 0;
  logic [HALF_W-1:0] pos = 0, sup = 0;
  logic [FLAG_N-1:0] ev = 0, flags;
  int num_errors = 0, compares = 0;
  msf_status_regs i_msf_status_regs(.mclk(mclk), .reset(reset), .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rv), .fault_event(ev), .speed_value(spd),
    .period_value(per), .velocity_const_value(kt), .peak_current_value(cur),
    .initial_position_estimate(pos), .supply_level_value(sup), .fault_flags(flags));
  msf_host_model i_msf_host_model(.mclk(mclk), .wr_en(wr), .rd_en(rd), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rd_valid(rv));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    i_msf_host_model.access(1'b0, a, 16'h0000, q);
    chk("rdata", q, exp);
  endtask : rd_chk
  task automatic finish_test();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic test_words();
    @(posedge mclk);
    spd <= 16'hfffe;
    per <= 16'h8001;
    kt <= 16'h1234;
    cur <= 11'h7ff;
    pos <= 8'ha5;
    sup <= 8'h67;
    i_msf_host_model.access(1'b1, OFS_SPEED, 16'h5555, q);
    rd_chk(OFS_SPEED, 16'hfffe);
    rd_chk(OFS_PERIOD, 16'h8001);
    rd_chk(OFS_VEL_CONST, 16'h1234);
    rd_chk(OFS_PEAK_CURR, 16'h07ff);
    rd_chk(OFS_POS_SUPPLY, 16'ha567);
    $display("test words done");
  endtask : test_words
  task automatic test_flags();
    @(posedge mclk);
    ev <= 6'h3f;
    @(posedge mclk);
    ev <= 6'h00;
    rd_chk(OFS_FAULT_FLAGS, 16'h003f);
    i_msf_host_model.access(1'b1, OFS_FAULT_FLAGS, 16'h0021, q);
    rd_chk(OFS_FAULT_FLAGS, 16'h001e);
    i_msf_host_model.access(1'b1, OFS_FAULT_FLAGS, 16'h0000, q);
    chk("fault_flags", {10'h000, flags}, 16'h001e);
    fork
      i_msf_host_model.access(1'b1, OFS_FAULT_FLAGS, 16'h0002, q);
      begin
        @(posedge mclk);
        ev <= 6'h02;
        @(posedge mclk);
        ev <= 6'h00;
      end
    join
    chk("set_wins", {10'h000, flags}, 16'h001e);
    i_msf_host_model.access(1'b1, OFS_FAULT_FLAGS, 16'h0002, q);
    chk("clear_one", {10'h000, flags}, 16'h001c);
    $display("test flags done");
  endtask : test_flags
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    for (int a = 0; a < 6; a++) rd_chk(a[7:0], RST_WORD);
    $display("test reset done");
    test_words();
    test_flags();
    finish_test();
  end
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule : msf_status_regs_bench
`default_nettype wire
